//--- inc/bflc_pkg.sv
// Purpose: Shared constants and types for the biphase frame line coder.
// Assumes: 200 MHz system clock; bit clock enables come from a phase accumulator.
// Notes:   Half-bit symbols are {first half level, second half level} in coax polarity.
package bflc_pkg;
    // Clock and line rates, in Hz
    localparam int CLK_HZ = 200000000;
    localparam int COAX_BIT_HZ = 2358700;
    localparam int TWINAX_BIT_HZ = 1000000;
    localparam int TICKS_PER_BIT = 8;
    // Phase accumulator: one eighth-bit tick enable per wrap, eight per bit
    localparam logic [31:0] NCO_MOD = 32'(CLK_HZ);
    localparam logic [31:0] NCO_INC_COAX = 32'(TICKS_PER_BIT * COAX_BIT_HZ);
    localparam logic [31:0] NCO_INC_TWINAX = 32'(TICKS_PER_BIT * TWINAX_BIT_HZ);
    // Cycles between two enables: floor and ceiling of the ratio
    localparam int COAX_GAP_LO = CLK_HZ / (TICKS_PER_BIT * COAX_BIT_HZ);
    localparam int COAX_GAP_HI = (CLK_HZ + TICKS_PER_BIT * COAX_BIT_HZ - 1)
                                 / (TICKS_PER_BIT * COAX_BIT_HZ);
    localparam int TWINAX_GAP_LO = CLK_HZ / (TICKS_PER_BIT * TWINAX_BIT_HZ);
    localparam int TWINAX_GAP_HI = (CLK_HZ + TICKS_PER_BIT * TWINAX_BIT_HZ - 1)
                                   / (TICKS_PER_BIT * TWINAX_BIT_HZ);
    // Sequence lengths (last bit index of each phase)
    localparam logic [2:0] TICK_LAST = 3'h7;
    localparam logic [7:0] QUIESCE_LAST = 8'h04;
    localparam logic [7:0] VIOL_LAST = 8'h02;
    localparam logic [7:0] FRAME_LAST = 8'h08;
    localparam logic [7:0] END_LAST = 8'h02;
    localparam logic [7:0] FILL_MIN = 8'h03;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_ONE = 8'h01;
    // Frame layout: sync bit then eight data bits, most significant first
    localparam int DATA_W = 8;
    localparam logic SYNC_BIT = 1'h1;
    localparam logic [4:0] ADDR_PAD = 5'h00;
    // Transmit buffer
    localparam int FIFO_WIDTH = DATA_W + 1;
    localparam int FIFO_DEPTH = 8;
    // Half-bit symbols
    localparam logic [1:0] SYM_LOW = 2'h0;
    localparam logic [1:0] SYM_ONE = 2'h1;
    localparam logic [1:0] SYM_ZERO = 2'h2;
    localparam logic [1:0] SYM_HIGH = 2'h3;

    typedef enum logic [1:0] {
        MODE_COAX = 2'h0,
        MODE_MUX = 2'h1,
        MODE_TWINAX = 2'h2,
        MODE_GENERAL = 2'h3
    } bflc_mode_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_QUIESCE = 3'h1,
        ST_VIOL = 3'h3,
        ST_FRAME = 3'h2,
        ST_FILL = 3'h6,
        ST_END = 3'h7
    } bflc_state_type;
endpackage

//--- hw/bflc_fifo.sv
// Purpose: Small FIFO holding transmit words ahead of the line coder.
// Assumes: DEPTH is a power of two; one clock, asynchronous active-low reset.
// Notes:   Head word sits in an output register; latency from push to valid is two cycles.
`timescale 1ns/100ps
module bflc_fifo #(
    parameter int WIDTH = bflc_pkg::FIFO_WIDTH,
    parameter int DEPTH = bflc_pkg::FIFO_DEPTH
) (
    input wire logic clock_i,             // System clock
    input wire logic rstn_i,              // Async reset, active low
    input wire logic wr_valid_i,          // Write word offered
    input wire logic [WIDTH-1:0] wr_data_i, // Write word
    output logic wr_ready_o,              // Room for a word
    output logic rd_valid_o,              // Head word valid
    output logic [WIDTH-1:0] rd_data_o,   // Head word
    input wire logic rd_ready_i           // Head word taken
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wptr_r;
    logic [AW-1:0] rptr_r;
    logic [AW:0] cnt_r;
    logic [AW:0] cnt_nxt;
    logic ready_r;
    logic valid_r;
    logic [WIDTH-1:0] data_r;

    // Handshakes; the output register refills whenever it empties or is taken
    wire push = wr_valid_i && ready_r;
    wire pop = rd_ready_i && valid_r;
    wire load = (!valid_r || pop) && (cnt_r != '0);
    assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(load);
    assign wr_ready_o = ready_r;
    assign rd_valid_o = valid_r;
    assign rd_data_o = data_r;

    // Storage array, no reset needed
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_r[wptr_r] <= wr_data_i;
        end
    end

    // Pointers, fill level and head register
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r <= '0;
            ready_r <= 1'b1;
            valid_r <= 1'b0;
            data_r <= '0;
        end else begin
            wptr_r <= wptr_r + AW'(push);
            rptr_r <= rptr_r + AW'(load);
            cnt_r <= cnt_nxt;
            ready_r <= cnt_nxt < (AW+1)'(DEPTH); // Honest full, stalls the source
            valid_r <= load || (valid_r && !pop);
            if (load) begin
                data_r <= mem_r[rptr_r];
            end
        end
    end
endmodule // bflc_fifo

//--- hw/bflc_line_coder.sv
// Purpose: Biphase frame line coder: quiesce, code violation, frames, fill and ending.
// Assumes: Config inputs come from same-clock logic and change only while idle.
// Notes:   Mode is latched while idle, so a message keeps one polarity and one rate.
`timescale 1ns/100ps
module bflc_line_coder (
    input wire logic clock_i,                  // 200 MHz system clock
    input wire logic rstn_i,                   // Async reset, active low
    input wire logic [1:0] mode_i,             // Protocol mode, latched while idle for transmit; the receive filter reads it live
    input wire logic [2:0] mux_addr_i,         // Port select for multiplexer mode
    input wire logic [7:0] fill_count_i,       // Twinax inter-frame fill bits
    input wire logic tx_valid_i,               // Transmit word offered
    input wire logic [7:0] tx_data_i,          // Transmit byte
    input wire logic tx_last_i,                // Word ends the message
    output logic tx_ready_o,                   // Buffer has room
    output logic line_o,                       // Serial line level
    output logic line_oe_o,                    // Line driven while high
    input wire logic rx_addr_stb_i,            // Received address frame strobe
    input wire logic [7:0] rx_addr_i,          // Received address frame
    input wire logic [7:0] station_addr_i,     // Own station address
    input wire logic promisc_i,                // Accept every address
    output logic rx_match_o                    // Received message accepted
);
    bflc_pkg::bflc_state_type st_r, st_nxt;
    bflc_pkg::bflc_mode_type mode_r, mode_nxt;
    logic [31:0] acc_r;
    logic tick_r;
    logic [2:0] tick_cnt_r;
    logic [7:0] bit_cnt_r, cnt_nxt;
    logic [8:0] shift_r, shift_nxt;
    logic last_r, last_nxt;
    logic is_addr_r, addr_nxt;
    logic end_r, end_nxt;
    logic [7:0] fill_lim_r, lim_nxt;
    logic pop;
    logic line_r;
    logic oe_r;
    logic rx_match_r;
    logic fifo_valid;
    logic [bflc_pkg::FIFO_WIDTH-1:0] fifo_data;

    // Level of a symbol in the given half of the bit
    function automatic logic half_level(input logic [1:0] sym, input logic second);
        half_level = second ? sym[0] : sym[1];
    endfunction

    bflc_fifo #(
        .WIDTH(bflc_pkg::FIFO_WIDTH),
        .DEPTH(bflc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .wr_valid_i(tx_valid_i),
        .wr_data_i({tx_last_i, tx_data_i}),
        .wr_ready_o(tx_ready_o),
        .rd_valid_o(fifo_valid),
        .rd_data_o(fifo_data),
        .rd_ready_i(pop)
    );

    // Phase accumulator; fractional ratio at coax rate, so enables jitter by one cycle
    wire inv = (mode_r == bflc_pkg::MODE_TWINAX);
    wire [31:0] nco_inc = inv ? bflc_pkg::NCO_INC_TWINAX : bflc_pkg::NCO_INC_COAX;
    wire [32:0] acc_sum = {1'b0, acc_r} + {1'b0, nco_inc};
    wire nco_wrap = acc_sum >= {1'b0, bflc_pkg::NCO_MOD};
    wire [31:0] acc_nxt = nco_wrap ? 32'(acc_sum - {1'b0, bflc_pkg::NCO_MOD}) : acc_sum[31:0];
    wire bit_end = tick_r && (tick_cnt_r == bflc_pkg::TICK_LAST);

    // Eighth-bit enable and tick counter
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            acc_r <= '0;
            tick_r <= 1'b0;
            tick_cnt_r <= '0;
        end else begin
            acc_r <= acc_nxt;
            tick_r <= nco_wrap;
            tick_cnt_r <= tick_cnt_r + 3'(tick_r);
        end
    end

    // Fill count floor; the 8-bit field covers the controller's full range
    wire [7:0] gap_lim = (fill_count_i < bflc_pkg::FILL_MIN) ? bflc_pkg::FILL_MIN
                                                              : fill_count_i;
    wire is_last = !is_addr_r && last_r;
    wire [8:0] addr_frame = {bflc_pkg::SYNC_BIT, bflc_pkg::ADDR_PAD, mux_addr_i};

    // Mode bits to enum
    function automatic bflc_pkg::bflc_mode_type bflc_bits_mode(input logic [1:0] m);
        bflc_bits_mode = bflc_pkg::bflc_mode_type'(m);
    endfunction

    // Sequencer: advances only on bit boundaries
    always_comb begin
        logic take;
        take = 1'b0;
        st_nxt = st_r;
        mode_nxt = (st_r == bflc_pkg::ST_IDLE) ? bflc_bits_mode(mode_i) : mode_r;
        cnt_nxt = bit_cnt_r + bflc_pkg::CNT_ONE;
        shift_nxt = {shift_r[7:0], 1'b0};
        last_nxt = last_r;
        addr_nxt = is_addr_r;
        end_nxt = end_r;
        lim_nxt = fill_lim_r;
        pop = 1'b0;
        if (!bit_end) begin
            cnt_nxt = bit_cnt_r;
            shift_nxt = shift_r;
        end else begin
            case (st_r)
                bflc_pkg::ST_IDLE: begin
                    cnt_nxt = bflc_pkg::CNT_ZERO;
                    if (fifo_valid) begin
                        st_nxt = bflc_pkg::ST_QUIESCE;
                    end
                end
                bflc_pkg::ST_QUIESCE: begin
                    if (bit_cnt_r == bflc_pkg::QUIESCE_LAST) begin
                        st_nxt = bflc_pkg::ST_VIOL;
                        cnt_nxt = bflc_pkg::CNT_ZERO;
                    end
                end
                bflc_pkg::ST_VIOL: begin
                    if (bit_cnt_r == bflc_pkg::VIOL_LAST) begin
                        if (mode_r == bflc_pkg::MODE_MUX) begin
                            st_nxt = bflc_pkg::ST_FRAME;
                            cnt_nxt = bflc_pkg::CNT_ZERO;
                            shift_nxt = addr_frame;
                            addr_nxt = 1'b1;
                        end else begin
                            take = 1'b1;
                        end
                    end
                end
                bflc_pkg::ST_FRAME: begin
                    if (bit_cnt_r == bflc_pkg::FRAME_LAST) begin
                        cnt_nxt = bflc_pkg::CNT_ZERO;
                        if (is_last || !fifo_valid) begin
                            if (inv) begin
                                st_nxt = bflc_pkg::ST_FILL;
                                lim_nxt = bflc_pkg::FILL_MIN;
                                end_nxt = 1'b1;
                            end else begin
                                st_nxt = bflc_pkg::ST_END;
                            end
                        end else if (inv) begin
                            st_nxt = bflc_pkg::ST_FILL;
                            lim_nxt = gap_lim;
                            end_nxt = 1'b0;
                        end else begin
                            take = 1'b1;
                        end
                    end
                end
                bflc_pkg::ST_FILL: begin
                    if (bit_cnt_r == 8'(fill_lim_r - bflc_pkg::CNT_ONE)) begin
                        if (end_r || !fifo_valid) begin
                            st_nxt = bflc_pkg::ST_IDLE;
                        end else begin
                            take = 1'b1;
                        end
                    end
                end
                default: begin
                    if (bit_cnt_r == bflc_pkg::END_LAST) begin
                        st_nxt = bflc_pkg::ST_IDLE;
                    end
                end
            endcase
        end
        // Next frame from the buffer: sync bit then data
        if (take) begin
            st_nxt = bflc_pkg::ST_FRAME;
            cnt_nxt = bflc_pkg::CNT_ZERO;
            shift_nxt = {bflc_pkg::SYNC_BIT, fifo_data[bflc_pkg::DATA_W-1:0]};
            last_nxt = fifo_data[bflc_pkg::DATA_W];
            addr_nxt = 1'b0;
            pop = 1'b1;
        end
    end

    // Symbol of the bit now on the line
    wire [1:0] viol_sym = (bit_cnt_r == bflc_pkg::CNT_ZERO) ? bflc_pkg::SYM_LOW :
                          (bit_cnt_r == bflc_pkg::CNT_ONE) ? bflc_pkg::SYM_ONE :
                          bflc_pkg::SYM_HIGH;
    wire [1:0] end_sym = (bit_cnt_r == bflc_pkg::CNT_ZERO) ? bflc_pkg::SYM_ZERO
                                                         : bflc_pkg::SYM_HIGH;
    wire [1:0] data_sym = shift_r[8] ? bflc_pkg::SYM_ONE : bflc_pkg::SYM_ZERO;
    wire [1:0] sym = (st_r == bflc_pkg::ST_QUIESCE) ? bflc_pkg::SYM_ONE :
                     (st_r == bflc_pkg::ST_VIOL) ? viol_sym :
                     (st_r == bflc_pkg::ST_FRAME) ? data_sym :
                     (st_r == bflc_pkg::ST_FILL) ? bflc_pkg::SYM_ZERO :
                     (st_r == bflc_pkg::ST_END) ? end_sym : bflc_pkg::SYM_LOW;
    wire busy = (st_r != bflc_pkg::ST_IDLE);
    wire level = busy && (half_level(sym, tick_cnt_r[2]) ^ inv);
    // Coax and mux modes always accept; filtering only where the protocol carries addresses
    wire filt_mode = (mode_i == bflc_pkg::MODE_TWINAX) || (mode_i == bflc_pkg::MODE_GENERAL);
    wire accept = !filt_mode || promisc_i || (rx_addr_i == station_addr_i);

    // Sequencer registers
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= bflc_pkg::ST_IDLE;
            mode_r <= bflc_pkg::MODE_COAX;
            bit_cnt_r <= '0;
            shift_r <= '0;
            last_r <= 1'b0;
            is_addr_r <= 1'b0;
            end_r <= 1'b0;
            fill_lim_r <= bflc_pkg::FILL_MIN;
        end else begin
            st_r <= st_nxt;
            mode_r <= mode_nxt;
            bit_cnt_r <= cnt_nxt;
            shift_r <= shift_nxt;
            last_r <= last_nxt;
            is_addr_r <= addr_nxt;
            end_r <= end_nxt;
            fill_lim_r <= lim_nxt;
        end
    end

    // Output registers; the line is released low while idle
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            line_r <= 1'b0;
            oe_r <= 1'b0;
            rx_match_r <= 1'b0;
        end else begin
            line_r <= level;
            oe_r <= busy;
            rx_match_r <= rx_addr_stb_i && accept;
        end
    end
    assign line_o = line_r;
    assign line_oe_o = oe_r;
    assign rx_match_o = rx_match_r;

    // Helper: cycles between enables while transmitting
    logic [7:0] gap_r;
    logic gap_ok_r;
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gap_r <= '0;
            gap_ok_r <= 1'b0;
        end else begin
            gap_r <= tick_r ? 8'h01 : 8'(gap_r + 8'h01);
            gap_ok_r <= busy && (gap_ok_r || tick_r);
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    sequence s_frame_done;
        st_r == bflc_pkg::ST_FRAME && bit_end && bit_cnt_r == bflc_pkg::FRAME_LAST;
    endsequence
    sequence s_viol_done;
        st_r == bflc_pkg::ST_VIOL && bit_end && bit_cnt_r == bflc_pkg::VIOL_LAST;
    endsequence

    coax_polarity_a: assert property (
        st_r == bflc_pkg::ST_FRAME && !inv && shift_r[8] |=> line_r == $past(tick_cnt_r[2]))
        else $error("coax one not a mid-bit rise");
    twinax_polarity_a: assert property (
        st_r == bflc_pkg::ST_FRAME && inv && shift_r[8] |=> line_r == !$past(tick_cnt_r[2]))
        else $error("twinax one not inverted");
    start_violation_a: assert property (
        st_r == bflc_pkg::ST_VIOL && bit_cnt_r != bflc_pkg::CNT_ONE
        |=> line_r == ($past(bit_cnt_r) == bflc_pkg::CNT_ZERO ? $past(inv) : !$past(inv)))
        else $error("start violation level wrong");
    ending_seq_a: assert property (
        s_frame_done ##0 (!inv && (is_last || !fifo_valid))
        |=> st_r == bflc_pkg::ST_END && bit_cnt_r == bflc_pkg::CNT_ZERO)
        else $error("coax ending sequence not started");
    mini_cv_a: assert property (
        st_r == bflc_pkg::ST_END && bit_cnt_r != bflc_pkg::CNT_ZERO |=> line_r)
        else $error("mini violation not high");
    twinax_no_mcv_a: assert property (
        st_r == bflc_pkg::ST_END |-> !inv)
        else $error("twinax sent an ending sequence");
    inter_fill_a: assert property (
        s_frame_done ##0 (inv && !is_last && fifo_valid)
        |=> st_r == bflc_pkg::ST_FILL && fill_lim_r == $past(gap_lim)
            && fill_lim_r >= bflc_pkg::FILL_MIN)
        else $error("inter-frame fill count wrong");
    final_fill_a: assert property (
        st_r == bflc_pkg::ST_FILL && end_r |-> fill_lim_r == bflc_pkg::FILL_MIN)
        else $error("final fill not three bits");
    coax_rate_a: assert property (
        tick_r && gap_ok_r && !inv
        |-> int'(gap_r) >= bflc_pkg::COAX_GAP_LO && int'(gap_r) <= bflc_pkg::COAX_GAP_HI)
        else $error("coax bit enable spacing wrong");
    twinax_rate_a: assert property (
        tick_r && gap_ok_r && inv
        |-> int'(gap_r) >= bflc_pkg::TWINAX_GAP_LO && int'(gap_r) <= bflc_pkg::TWINAX_GAP_HI)
        else $error("twinax bit enable spacing wrong");
    addr_frame_a: assert property (
        s_viol_done ##0 (mode_r == bflc_pkg::MODE_MUX)
        |=> is_addr_r && shift_r == {bflc_pkg::SYNC_BIT, bflc_pkg::ADDR_PAD, $past(mux_addr_i)})
        else $error("address frame missing");
    rx_filter_a: assert property (
        rx_addr_stb_i && !promisc_i && rx_addr_i != station_addr_i
        && mode_i == bflc_pkg::MODE_GENERAL |=> !rx_match_r)
        else $error("filtered address accepted");
    quiesce_count_a: assert property (
        st_r == bflc_pkg::ST_QUIESCE && bit_end
        |=> (st_r == bflc_pkg::ST_VIOL) == ($past(bit_cnt_r) == bflc_pkg::QUIESCE_LAST))
        else $error("quiesce count not five");
    sync_bit_a: assert property (
        st_r == bflc_pkg::ST_FRAME && bit_cnt_r == bflc_pkg::CNT_ZERO |-> shift_r[8])
        else $error("frame without sync bit");
endmodule // bflc_line_coder

//--- testbench/bflc_rx_model.sv
// Purpose: Far-side receiver that cuts the driven line into half-bit cells.
// Assumes: Half-bit length given in hundredths of a system clock cycle.
// Notes:   Only driven cycles count; an undriven line carries no symbols.
`timescale 1ns/100ps
module bflc_rx_model (
    input wire logic clock_i,             // System clock
    input wire logic line_i,              // Line level
    input wire logic line_oe_i,           // Line driven
    input wire logic [15:0] half_x100_i   // Half-bit length, cycles times 100
);
    logic halves[$];
    int oe_cyc = 0;
    int run = 0;
    logic lvl = 1'b0;

    // Rounding a run to whole cells absorbs the 10/11 cycle enable jitter
    task automatic flush();
        repeat ((run * 100 + half_x100_i / 2) / half_x100_i) halves.push_back(lvl);
        run = 0;
    endtask

    // Measure each constant-level run while driven; close it on a change or release
    // Sampled on the falling edge, where the registered line has settled
    always @(negedge clock_i) begin
        if (line_oe_i === 1'b1) begin
            oe_cyc++;
            if (run > 0 && line_i !== lvl) flush();
            lvl = line_i;
            run++;
        end else if (run > 0) begin
            flush();
        end
    end
endmodule // bflc_rx_model

//--- testbench/tb_biphase_frame_line_coder.sv
// Purpose: Self-checking bench for the line coder: symbols, sequences, rate, buffer, filter.
// Assumes: Expected half-bit streams are built in coax polarity, inverted for twinax.
// Notes:   Rate is judged on the whole driven span, so single enable jitter is tolerated.
`timescale 1ns/100ps
module tb_biphase_frame_line_coder;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [1:0] mode_i = 2'h0;
    logic [2:0] mux_addr_i = 3'h5;
    logic [7:0] fill_count_i = 8'h00, tx_data_i = 8'h00, rx_addr_i = 8'h00, station_addr_i = 8'h2C;
    logic tx_valid_i = 1'b0, tx_last_i = 1'b0, rx_addr_stb_i = 1'b0, promisc_i = 1'b0;
    logic tx_ready_o, line_o, line_oe_o, rx_match_o, refused;
    logic [15:0] half_x100 = 16'h1090;
    logic exp[$];
    int checked = 0;
    int miscompares = 0;

    bflc_line_coder i_dut (.clock_i(clock_i), .rstn_i(rstn_i), .mode_i(mode_i),
        .mux_addr_i(mux_addr_i), .fill_count_i(fill_count_i), .tx_valid_i(tx_valid_i),
        .tx_data_i(tx_data_i), .tx_last_i(tx_last_i), .tx_ready_o(tx_ready_o), .line_o(line_o),
        .line_oe_o(line_oe_o), .rx_addr_stb_i(rx_addr_stb_i), .rx_addr_i(rx_addr_i),
        .station_addr_i(station_addr_i), .promisc_i(promisc_i), .rx_match_o(rx_match_o));
    bflc_rx_model i_rx (.clock_i(clock_i), .line_i(line_o), .line_oe_i(line_oe_o),
        .half_x100_i(half_x100));

    // 200 MHz clock
    initial begin
        forever #2.5 clock_i = ~clock_i;
    end

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %0h seen %0h", what, e, s);
        end
    endtask

    // One bit in coax polarity: one is low then high
    task automatic put(input logic b);
        exp.push_back(~b);
        exp.push_back(b);
    endtask

    task automatic put_frame(input logic [7:0] d);
        put(1'b1);
        for (int i = 7; i >= 0; i--) put(d[i]);
    endtask

    // Send one message of n words and compare the decoded line against the expected stream
    task automatic run_msg(input logic [1:0] m, input logic [7:0] fc, input int n,
                           input logic [7:0] base);
        logic rdy;
        logic seen;
        int t;
        int bad;
        longint diff;
        exp.delete();
        i_rx.halves.delete();
        i_rx.oe_cyc = 0;
        refused = 1'b0;
        @(posedge clock_i);
        mode_i <= m;
        fill_count_i <= fc;
        half_x100 <= (m == bflc_pkg::MODE_TWINAX) ? 16'h2710 : 16'h1090;
        repeat (5) put(1'b1);
        for (int i = 0; i < 6; i++) exp.push_back(i > 2);
        if (m == bflc_pkg::MODE_MUX) put_frame({5'h00, mux_addr_i});
        for (int i = 0; i < n; i++) begin
            put_frame(base + 8'(i) * 8'h3B);
            if (m == bflc_pkg::MODE_TWINAX && i < n - 1) repeat ((fc < 8'h03) ? 3 : int'(fc)) put(1'b0);
        end
        if (m == bflc_pkg::MODE_TWINAX) begin
            repeat (3) put(1'b0);
            foreach (exp[i]) exp[i] = ~exp[i];
        end else begin
            put(1'b0);
            repeat (4) exp.push_back(1'b1);
        end
        // Hold each word until an edge finds room for it
        for (int i = 0; i < n; i++) begin
            tx_valid_i <= 1'b1;
            tx_data_i <= base + 8'(i) * 8'h3B;
            tx_last_i <= (i == n - 1);
            do begin
                @(negedge clock_i);
                rdy = tx_ready_o;
                if (rdy !== 1'b1) refused = 1'b1;
                @(posedge clock_i);
            end while (rdy !== 1'b1);
        end
        tx_valid_i <= 1'b0;
        t = 0;
        seen = 1'b0;
        while (!(seen && line_oe_o === 1'b0) && t < 20000) begin
            @(posedge clock_i);
            seen = seen | (line_oe_o === 1'b1);
            t++;
        end
        repeat (2) @(posedge clock_i);
        check("transmission finished", 32'h1, 32'(t < 20000));
        check("half-bit count", exp.size(), i_rx.halves.size());
        bad = -1;
        foreach (exp[i]) if (bad < 0 && i < i_rx.halves.size() && i_rx.halves[i] !== exp[i]) bad = i;
        check("first wrong half-bit", 32'hFFFFFFFF, bad);
        diff = longint'(i_rx.oe_cyc) * 100 - longint'(exp.size() / 2) * ((m == bflc_pkg::MODE_TWINAX) ? 20000 : 8479);
        check("line rate", 32'h1, 32'(diff <= 3000 && diff >= -3000));
        $display("test done: mode %0d words %0d fill %0d", m, n, fc);
    endtask

    // One address strobe, then the match pulse one cycle later
    task automatic filt(input logic [1:0] m, input logic p, input logic [7:0] a, input logic e);
        @(posedge clock_i);
        mode_i <= m;
        promisc_i <= p;
        rx_addr_i <= a;
        rx_addr_stb_i <= 1'b1;
        @(posedge clock_i);
        rx_addr_stb_i <= 1'b0;
        @(negedge clock_i);
        check("address match", e, rx_match_o);
        @(negedge clock_i);
        check("match pulse width", 32'h0, rx_match_o);
        $display("test done: filter mode %0d promisc %0d", m, p);
    endtask

    task automatic test_coax_one();
        run_msg(bflc_pkg::MODE_COAX, 8'h00, 1, 8'hA5);
    endtask

    // Reset while the line is driven: outputs drop at once and nothing restarts
    task automatic test_reset_mid();
        logic busy_seen;
        busy_seen = 1'b0;
        @(posedge clock_i);
        tx_valid_i <= 1'b1;
        tx_data_i <= 8'h77;
        tx_last_i <= 1'b1;
        @(posedge clock_i);
        tx_valid_i <= 1'b0;
        wait (line_oe_o === 1'b1);
        @(posedge clock_i);
        rstn_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        rstn_i <= 1'b1;
        @(negedge clock_i);
        check("mid-run reset outputs", 32'h8, {tx_ready_o, line_oe_o, line_o, rx_match_o});
        repeat (200) begin
            @(negedge clock_i);
            busy_seen = busy_seen | (line_oe_o !== 1'b0);
        end
        check("idle after reset", 32'h0, busy_seen);
        $display("test done: reset in mid-run");
    endtask

    task automatic test_mux();
        run_msg(bflc_pkg::MODE_MUX, 8'h00, 2, 8'h3C);
    endtask

    task automatic test_general();
        run_msg(bflc_pkg::MODE_GENERAL, 8'h00, 1, 8'h96);
    endtask

    task automatic test_twinax_min();
        run_msg(bflc_pkg::MODE_TWINAX, 8'h00, 2, 8'h5A);
    endtask

    task automatic test_twinax_fill();
        run_msg(bflc_pkg::MODE_TWINAX, 8'h05, 3, 8'hC3);
    endtask

    // Ten words overrun the buffer, so the source must be stalled once
    task automatic test_coax_burst();
        run_msg(bflc_pkg::MODE_COAX, 8'h00, 10, 8'h11);
        check("buffer refused a word", 32'h1, refused);
    endtask

    task automatic test_filter();
        filt(bflc_pkg::MODE_COAX, 1'b0, 8'h13, 1'b1);
        filt(bflc_pkg::MODE_MUX, 1'b0, 8'h13, 1'b1);
        filt(bflc_pkg::MODE_TWINAX, 1'b0, 8'h2C, 1'b1);
        filt(bflc_pkg::MODE_TWINAX, 1'b0, 8'h13, 1'b0);
        filt(bflc_pkg::MODE_GENERAL, 1'b1, 8'h13, 1'b1);
        filt(bflc_pkg::MODE_GENERAL, 1'b0, 8'h13, 1'b0);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog: the tests need about 32k cycles, so 60k cycles means a hang
    initial begin
        #300000;
        miscompares++;
        finish_test();
    end

    initial begin
        repeat (2) @(posedge clock_i);
        rstn_i <= 1'b1;
        @(negedge clock_i);
        check("reset outputs", 32'h8, {tx_ready_o, line_oe_o, line_o, rx_match_o});
        test_coax_one();
        test_reset_mid();
        test_mux();
        test_general();
        test_twinax_min();
        test_twinax_fill();
        test_coax_burst();
        test_filter();
        finish_test();
    end
endmodule // tb_biphase_frame_line_coder
